// ### include/rmt_pkg.sv
// shared constants and carrier types of the truncating 12x12 multiplier
package rmt_pkg;
    localparam int OPERAND_W   = 12;
    localparam int PRODUCT_W   = 24;
    localparam int RESULT_W    = 16;
    localparam int RESULT_LSB  = 8;
    localparam int RESULT_MSB  = 23;
    localparam int SIGN_BIT    = 11;
    localparam int WRAP_BIT    = 22;
    localparam int SYNC_STAGES = 2;
    localparam int BUF_DEPTH   = 2;
    localparam logic [1:0] BUF_CNT_EMPTY = 2'h0;
    localparam logic [1:0] BUF_CNT_ONE   = 2'h1;
    localparam logic [1:0] BUF_CNT_FULL  = 2'h2;
    localparam logic [11:0] OPERAND_RST = 12'h000;
    localparam logic [15:0] RESULT_RST  = 16'h0000;

    typedef logic [OPERAND_W-1:0] rmt_operand_t;
    typedef logic [RESULT_W-1:0]  rmt_result_t;
    typedef logic [PRODUCT_W-1:0] rmt_product_t;

    // everything sampled from the pins, synchronised as one group
    typedef struct packed {
        logic         first_operand_clock;
        logic         shared_load_clock;
        logic         signed_select;
        rmt_operand_t first_operand;
        rmt_operand_t second_operand;
    } rmt_pins_t;

    localparam rmt_pins_t PINS_RST = '{1'b0, 1'b0, 1'b0, OPERAND_RST, OPERAND_RST};
endpackage : rmt_pkg

// ### verilog/rmt_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module rmt_buf2 #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [1:0]       cnt_r;
    logic [WIDTH-1:0] ent0_r;
    logic [WIDTH-1:0] ent1_r;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != rmt_pkg::BUF_CNT_FULL);
    assign out_valid = (cnt_r != rmt_pkg::BUF_CNT_EMPTY);
    assign out_data  = ent0_r;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            cnt_r <= rmt_pkg::BUF_CNT_EMPTY;
        else if (push && !pop)
            cnt_r <= cnt_r + rmt_pkg::BUF_CNT_ONE;
        else if (pop && !push)
            cnt_r <= cnt_r - rmt_pkg::BUF_CNT_ONE;
    end

    // entry 0 is always the head; entry 1 only holds a second word
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ent0_r <= '0;
            ent1_r <= '0;
        end
        else
        begin
            if (pop)
                ent0_r <= (cnt_r == rmt_pkg::BUF_CNT_FULL) ? ent1_r : in_data;
            else if (push && cnt_r == rmt_pkg::BUF_CNT_EMPTY)
                ent0_r <= in_data;
            if (push && (cnt_r == rmt_pkg::BUF_CNT_FULL || (cnt_r == rmt_pkg::BUF_CNT_ONE && !pop)))
                ent1_r <= in_data;
        end
    end
endmodule : rmt_buf2

// ### verilog/rmt_top.sv
// truncating 12x12 multiplier with registered operands and three-state result
//
// Overview of operation
// RQ1: two 12-bit operands, each held in its own input register
// RQ2: one format for both operands, signed or unsigned, never mixed
// RQ3: all registers capture only on rising edges of their clock
// RQ4: first operand loads on each rising edge of first_operand_clock
// RQ5: shared_load_clock loads second operand and result register together
// RQ6: result register keeps product bits 23 down to 8 on result_word
// RQ7: lower product bits are dropped with no rounding
// RQ8: result_word drives while drive_enable_n low, released while high, unclocked
// RQ9: operand bit 11 is the MSB and sign; bit 0 the LSB
// RQ10: in signed format the result MSB is the product sign
// RQ11: multiplication is pure combinational logic between the registers
// RQ12: format select is registered with the operands and governs the array
// RQ13: driving logic keeps a constant by not clocking its register again
// RQ14: driving logic should keep constants in the first operand register
// RQ15: each shared edge captures second operand, format and array result together
// RQ16: squaring signed full-scale negative gives the wrapped negative result
// RQ17: result uses operands registered before the edge, one load of latency
// RQ18: no functional reset of data; result holds between shared edges; here nrst clears the operand, format and result registers to zero
`timescale 1ns/100ps
module rmt_top (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    // operand pins
    input  wire logic                  first_operand_clock,
    input  wire logic                  shared_load_clock,
    input  wire logic                  signed_select,
    input  wire rmt_pkg::rmt_operand_t first_operand,
    input  wire rmt_pkg::rmt_operand_t second_operand,
    // three-state result port
    input  wire logic                  drive_enable_n,
    output rmt_pkg::rmt_result_t       result_word_o,
    output logic                       result_word_oe,
    // result stream
    output logic                       result_valid,
    input  wire logic                  result_ready,
    output rmt_pkg::rmt_result_t       result_data,
    output logic                       result_space
);
    rmt_pkg::rmt_pins_t    pins_in;
    rmt_pkg::rmt_pins_t    sync_q [rmt_pkg::SYNC_STAGES];
    rmt_pkg::rmt_pins_t    pins_s;
    logic                  first_clk_prev_r;
    logic                  shared_clk_prev_r;
    logic                  first_en;
    logic                  shared_en;
    rmt_pkg::rmt_operand_t first_r;
    rmt_pkg::rmt_operand_t second_r;
    logic                  signed_r;
    rmt_pkg::rmt_product_t product;
    rmt_pkg::rmt_result_t  result_nxt;
    rmt_pkg::rmt_result_t  result_r;

    assign pins_in = '{first_operand_clock, shared_load_clock, signed_select, first_operand, second_operand};

    // two-flop synchroniser; only the last stage is read by logic
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < rmt_pkg::SYNC_STAGES; i++)
                sync_q[i] <= rmt_pkg::PINS_RST;
        end
        else
        begin
            sync_q[0] <= pins_in;
            for (int i = 1; i < rmt_pkg::SYNC_STAGES; i++)
                sync_q[i] <= sync_q[i-1];
        end
    end

    assign pins_s = sync_q[rmt_pkg::SYNC_STAGES-1];

    // rising-edge detection turns each pin clock into a one-cycle enable
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            first_clk_prev_r  <= 1'b0;
            shared_clk_prev_r <= 1'b0;
        end
        else
        begin
            first_clk_prev_r  <= pins_s.first_operand_clock;
            shared_clk_prev_r <= pins_s.shared_load_clock;
        end
    end

    assign first_en  = pins_s.first_operand_clock && !first_clk_prev_r; // RQ3
    assign shared_en = pins_s.shared_load_clock && !shared_clk_prev_r; // RQ3

    // first operand register, own clock
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            first_r <= rmt_pkg::OPERAND_RST;
        else if (first_en)
            first_r <= pins_s.first_operand; // RQ1 RQ4
    end

    // second operand and format register, shared clock
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            second_r <= rmt_pkg::OPERAND_RST;
            signed_r <= 1'b0;
        end
        else if (shared_en)
        begin
            second_r <= pins_s.second_operand; // RQ1 RQ5 RQ15
            signed_r <= pins_s.signed_select; // RQ12 RQ15
        end
    end

    // combinational array over the registered operands and format
    always_comb
    begin
        if (signed_r) // RQ2 RQ12
        begin
            // sign-extend both operands to the product width so the low bits come out exact
            product = {{rmt_pkg::OPERAND_W{first_r[rmt_pkg::SIGN_BIT]}}, first_r}
                    * {{rmt_pkg::OPERAND_W{second_r[rmt_pkg::SIGN_BIT]}}, second_r}; // RQ9 RQ11
            // only 23 significant bits: full-scale negative squared wraps
            product[rmt_pkg::RESULT_MSB] = product[rmt_pkg::WRAP_BIT]; // RQ10 RQ16
        end
        else
        begin
            product = {{rmt_pkg::OPERAND_W{1'b0}}, first_r}
                    * {{rmt_pkg::OPERAND_W{1'b0}}, second_r}; // RQ2 RQ11
        end
    end

    assign result_nxt = product[rmt_pkg::RESULT_MSB:rmt_pkg::RESULT_LSB]; // RQ6 RQ7

    // result register loads on the same enable as the second operand
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            result_r <= rmt_pkg::RESULT_RST;
        else if (shared_en)
            result_r <= result_nxt; // RQ5 RQ15 RQ17 RQ18
    end

    assign result_word_o  = result_r; // RQ6
    assign result_word_oe = !drive_enable_n; // RQ8

    // each shared load also offers the new word to the stream buffer
    rmt_buf2 #(
        .WIDTH (rmt_pkg::RESULT_W)
    ) u_buf (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .in_valid  (shared_en),
        .in_ready  (result_space),
        .in_data   (result_nxt),
        .out_valid (result_valid),
        .out_ready (result_ready),
        .out_data  (result_data)
    );
endmodule : rmt_top

// ### tb/rmt_top_monitor.sv
// port assertions of the truncating multiplier
`timescale 1ns/100ps
module rmt_top_monitor (
    // clock and reset
    input wire logic                 sys_clk,
    input wire logic                 nrst,
    // pins
    input wire logic                 shared_load_clock,
    input wire logic                 drive_enable_n,
    // result
    input wire rmt_pkg::rmt_result_t result_word_o,
    input wire logic                 result_word_oe,
    input wire logic                 result_valid,
    input wire logic                 result_ready,
    input wire rmt_pkg::rmt_result_t result_data,
    input wire logic                 result_space
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    oe_follow_a: assert property (
        result_word_oe == !drive_enable_n) else $error("enable mismatch");
    word_hold_a: assert property (
        !$stable(result_word_o) |-> $past(shared_load_clock, 3) && !$past(shared_load_clock, 4))
        else $error("word changed without load");
    push_match_a: assert property (
        $past(shared_load_clock, 3) && !$past(shared_load_clock, 4) && !$past(result_valid)
        |-> result_valid && result_data == result_word_o) else $error("pushed word wrong");
    stream_hold_a: assert property (
        result_valid && !result_ready |=> result_valid && $stable(result_data)) else $error("head lost");
    full_valid_a: assert property (!result_space |-> result_valid) else $error("full but empty");
    empty_room_a: assert property (!result_valid |-> result_space) else $error("empty but full");
    pop_room_a: assert property (
        $past(result_valid) && $past(result_ready) |-> result_space) else $error("no room after pop");
    reset_value_a: assert property (
        disable iff (1'b0) !nrst |-> result_word_o == 16'h0000 && !result_valid && result_space)
        else $error("reset values wrong");
endmodule : rmt_top_monitor
bind rmt_top rmt_top_monitor u_mon (.sys_clk(sys_clk), .nrst(nrst), .shared_load_clock(shared_load_clock),
    .drive_enable_n(drive_enable_n), .result_word_o(result_word_o), .result_word_oe(result_word_oe),
    .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data), .result_space(result_space));

// ### tb/rmt_sink.sv
// stream sink that accepts at random or stalls on request
`timescale 1ns/100ps
module rmt_sink (
    // clock
    input  wire logic sys_clk,
    // control
    input  wire logic stall,
    // handshake
    output logic      result_ready
);
    initial result_ready = 1'b0;
    always @(posedge sys_clk)
        result_ready <= !stall && ($urandom % 4 != 0);
endmodule : rmt_sink

// ### tb/tb.sv
// self-checking bench of the truncating multiplier
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
    logic                 sys_clk = 0, nrst = 1, fck = 0, sck = 0, sgn = 0, oe_n = 1, stall = 0, ms = 0, s;
    logic                 ready, valid, space, oe;
    rmt_pkg::rmt_operand_t fop = '0, sop = '0, ma = '0, mb = '0, a, b;
    rmt_pkg::rmt_result_t  word, data, e, w, q[$];
    int                    fails = 0, checked = 0;
    rmt_top DUT (.sys_clk(sys_clk), .nrst(nrst), .first_operand_clock(fck), .shared_load_clock(sck),
        .signed_select(sgn), .first_operand(fop), .second_operand(sop), .drive_enable_n(oe_n),
        .result_word_o(word), .result_word_oe(oe), .result_valid(valid), .result_ready(ready),
        .result_data(data), .result_space(space));
    rmt_sink u_sink (.sys_clk(sys_clk), .stall(stall), .result_ready(ready));
    initial forever #2 sys_clk = ~sys_clk;
    function automatic rmt_pkg::rmt_result_t expect_word(rmt_pkg::rmt_operand_t x, y, logic t);
        logic [23:0] p;
        p = t ? 24'($signed(x)) * 24'($signed(y)) : 24'(x) * 24'(y);
        p[23] = t ? p[22] : p[23];
        return p[23:8];
    endfunction : expect_word
    task pulse(input logic shared);
        @(posedge sys_clk);
        if (shared)
            sck <= 1'b1;
        else
            fck <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sck <= 1'b0;
        fck <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : pulse
    task conclude;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    always @(posedge sys_clk)
        if (nrst && valid === 1'b1 && ready === 1'b1)
        begin
            e = (q.size() > 0) ? q.pop_front() : ~data;
            `CHK("result_data", e, data)
        end
    initial
    begin
        // a real falling edge so the asynchronous reset acts before the first clock
        nrst <= 1'b0;
        void'($urandom(32'h50B6));
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        `CHK("reset word", 16'h0000, word)
        for (int i = 0; i < 2; i++)
        begin
            @(posedge sys_clk);
            oe_n <= i[0];
            #1;
            `CHK("enable", ~i[0], oe)
        end
        $display("test reset and enable done");
        for (int i = 0; i < 24; i++)
        begin
            a = i < 2 ? 12'h800 : i < 4 ? 12'hFFF : 12'($urandom);
            b = i < 2 ? 12'h800 : i < 4 ? 12'hFFF : 12'($urandom);
            s = i < 2 ? 1'b1 : i < 4 ? 1'b0 : 1'($urandom);
            #1;
            if (i == 20)
                `CHK("space", 1'b0, space)
            @(posedge sys_clk);
            fop <= a;
            sop <= b;
            sgn <= s;
            stall <= i >= 16 && i < 20;
            // every third pass keeps the first operand as a constant
            if (i % 3 != 1)
                ma = a;
            if (i % 3 != 1)
                pulse(1'b0);
            // outside the stall window the sink empties the buffer before the next load
            for (int n = 0; n < 64 && (i < 16 || i >= 20) && q.size() > 0; n++)
                @(posedge sys_clk);
            if ((i < 16 || i >= 20) && q.size() > 0)
            begin
                fails++;
                conclude();
            end
            w = expect_word(ma, mb, ms);
            if (q.size() < 2)
                q.push_back(w);
            mb = b;
            ms = s;
            pulse(1'b1);
            `CHK("result_word", w, word)
        end
        for (int n = 0; n < 64 && q.size() > 0; n++)
            @(posedge sys_clk);
        `CHK("pending", 0, q.size())
        $display("test multiply stream done");
        conclude();
    end
endmodule : tb
